// ### core/cyhc_pkg.sv
// Purpose: Shared constants for the cycle history capture block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses on the register bus
package cyhc_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRE = 8'h04;
  localparam logic [7:0] ADDR_MAXS = 8'h08;
  localparam logic [7:0] ADDR_TCYC = 8'h0C;
  localparam logic [7:0] ADDR_VOFF = 8'h10;
  localparam logic [7:0] ADDR_COFF = 8'h14;
  localparam logic [7:0] ADDR_HBUF = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_CNT = 8'h20;
  // ************************************************************
  // Control fields and reset values
  // ************************************************************
  localparam int CTRL_FIN_BIT = 0;
  localparam int CTRL_ALL_BIT = 1;
  localparam int CTRL_TT_LSB = 2;
  localparam int CTRL_FETCH_BIT = 4;
  localparam logic [1:0] TT_MISCOMPARE = 2'h0;
  localparam logic [1:0] TT_CYCLE = 2'h1;
  localparam logic [1:0] TT_LABEL = 2'h2;
  localparam logic [31:0] RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] RST_MAXS = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_HBUF = 32'h0000_7D00;
  localparam logic [31:0] MAXS_UNLIMITED = 32'hFFFF_FFFF;
  // ************************************************************
  // Capture states
  // ************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARMED = 5'b00010,
    ST_VSKIP = 5'b00100,
    ST_CSKIP = 5'b01000,
    ST_CAPT = 5'b10000
  } cyhc_state_type;
endpackage

// ### core/cyhc_capture.sv
// Purpose: Cycle history capture with trigger, pretrigger and streaming
// Assumes: Burst engine signals arrive on clock_i; DEPTH is a power of 2
// Notes: Samples leave through an output FIFO towards the host
//
// The address map and register access over APB were chosen for this implementation.

// ************************************************************
// Output FIFO
// ************************************************************
module cyhc_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] cnt;
    logic [AW-1:0] wp, rp;
    logic ov;
    logic [WIDTH-1:0] od;
  } cyhc_fifo_type;
  cyhc_fifo_type r_ff, nxt_r;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push, load;
  // Output stage refills whenever it is empty or being taken
  always_comb begin
    nxt_r = r_ff;
    push = in_valid_i && (r_ff.cnt != (AW+1)'(DEPTH));
    load = (r_ff.cnt != '0) && (!r_ff.ov || out_ready_i);
    if (out_ready_i) begin
      nxt_r.ov = 1'b0;
    end
    if (load) begin
      nxt_r.ov = 1'b1;
      nxt_r.od = mem_ff[r_ff.rp];
      nxt_r.rp = r_ff.rp + 1'b1;
    end
    if (push) begin
      nxt_r.wp = r_ff.wp + 1'b1;
    end
    nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(load);
  end
  // State and storage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
    if (push) begin
      mem_ff[r_ff.wp] <= in_data_i;
    end
  end
  assign in_ready_o = (r_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = r_ff.ov;
  assign out_data_o = r_ff.od;
endmodule

// ************************************************************
// Capture controller
// ************************************************************
module cyhc_capture #(
  parameter int PINS = 8,
  parameter int DEPTH = 64,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic burst_start_i,
  input wire logic cyc_valid_i,
  input wire logic [31:0] cyc_num_i,
  input wire logic [PINS-1:0] cyc_fail_i,
  input wire logic label_hit_i,
  input wire logic vector_start_i,
  output logic smp_valid_o,
  input wire logic smp_ready_i,
  output logic [31+PINS:0] smp_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int SW = 32 + PINS;
  localparam logic [31:0] DEPTH_W = 32'(DEPTH);
  typedef struct packed {
    cyhc_pkg::cyhc_state_type st;
    logic fin, all, fetch;
    logic [1:0] tt;
    logic [31:0] pre, maxs, tcyc, voff, coff, hbuf;
    logic [AW:0] wr, rd;
    logic [31:0] total, sent, vcnt, ccnt, prdata;
    logic pready, pslverr;
  } cyhc_regs_type;
  cyhc_regs_type r_ff, nxt_r;
  logic [SW-1:0] hist_ff [DEPTH];
  logic [AW:0] occ;
  logic [31:0] pre_cap, v_eff, c_eff, tot;
  logic acc, fail, trig, lh, vreach, room, wr_en, push, fifo_rdy, drain;

  // ************************************************************
  // Register bus, trigger and capture
  // ************************************************************
  // One cycle of wait state, answer registered with pready
  always_comb begin
    nxt_r = r_ff;
    nxt_r.pready = 1'b0;
    nxt_r.pslverr = 1'b0;
    acc = psel_i && penable_i && !r_ff.pready;
    fail = |cyc_fail_i;
    occ = r_ff.wr - r_ff.rd;
    pre_cap = (r_ff.pre > DEPTH_W - 1) ? DEPTH_W - 1 : r_ff.pre;
    if (pre_cap > r_ff.maxs) pre_cap = r_ff.maxs;
    tot = (r_ff.st == cyhc_pkg::ST_CAPT) ? r_ff.total : 32'(occ); // Window too
    trig = 1'b0;
    wr_en = 1'b0;
    // Label path: vectors counted first, then cycles
    lh = (r_ff.st == cyhc_pkg::ST_ARMED) && label_hit_i;
    v_eff = lh ? '0 : (vector_start_i ? r_ff.vcnt + 1 : r_ff.vcnt);
    vreach = (lh || r_ff.st == cyhc_pkg::ST_VSKIP) &&
             (v_eff == r_ff.voff);
    c_eff = (r_ff.st == cyhc_pkg::ST_CSKIP) ? r_ff.ccnt + 1 : '0;
    // Room under both the memory depth and the sample limit
    room = (occ != (AW+1)'(DEPTH)) &&
           (!r_ff.fin || tot < DEPTH_W) &&
           (r_ff.maxs == cyhc_pkg::MAXS_UNLIMITED ||
            tot < r_ff.maxs);
    // Trigger detection per selected type
    if (cyc_valid_i) begin
      if (r_ff.tt == cyhc_pkg::TT_MISCOMPARE) begin
        trig = (r_ff.st == cyhc_pkg::ST_ARMED) && fail;
      end else if (r_ff.tt == cyhc_pkg::TT_CYCLE) begin
        trig = (r_ff.st == cyhc_pkg::ST_ARMED) &&
               (cyc_num_i == r_ff.tcyc);
      end else if (r_ff.tt == cyhc_pkg::TT_LABEL) begin
        trig = (vreach || r_ff.st == cyhc_pkg::ST_CSKIP) &&
               (c_eff == r_ff.coff);
      end
    end
    case (r_ff.st)
      cyhc_pkg::ST_ARMED, cyhc_pkg::ST_VSKIP, cyhc_pkg::ST_CSKIP: begin
        if (cyc_valid_i && trig) begin
          nxt_r.st = cyhc_pkg::ST_CAPT;
          wr_en = (r_ff.all || fail) && room;
          nxt_r.total = 32'(occ) + 32'(wr_en);
        end else if (cyc_valid_i) begin
          // Rolling pretrigger window, oldest entry dropped
          wr_en = (pre_cap != '0);
          if (wr_en && 32'(occ) == pre_cap) begin
            nxt_r.rd = r_ff.rd + 1'b1;
          end
          if (r_ff.tt == cyhc_pkg::TT_LABEL && vreach) begin
            nxt_r.st = cyhc_pkg::ST_CSKIP;
            nxt_r.ccnt = '0;
          end else if (r_ff.tt == cyhc_pkg::TT_LABEL &&
                       (lh || r_ff.st == cyhc_pkg::ST_VSKIP)) begin
            nxt_r.st = cyhc_pkg::ST_VSKIP;
            nxt_r.vcnt = v_eff;
          end else if (r_ff.st == cyhc_pkg::ST_CSKIP) begin
            nxt_r.ccnt = c_eff;
          end
        end
      end
      cyhc_pkg::ST_CAPT: begin
        wr_en = cyc_valid_i && (r_ff.all || fail) && room;
        nxt_r.total = r_ff.total + 32'(wr_en);
      end
      default: wr_en = 1'b0;
    endcase
    if (wr_en) begin
      nxt_r.wr = r_ff.wr + 1'b1;
    end
    // Drain to host: fetch in finite mode, automatic otherwise
    drain = (r_ff.st == cyhc_pkg::ST_CAPT) &&
            (r_ff.fin ? r_ff.fetch : 1'b1);
    push = drain && (occ != '0) && (r_ff.sent < r_ff.hbuf) && fifo_rdy;
    if (push) begin
      nxt_r.rd = r_ff.rd + 1'b1;
      nxt_r.sent = r_ff.sent + 1;
    end
    if (drain && occ == '0) begin
      nxt_r.fetch = 1'b0;
    end
    // New burst rearms and empties the window
    if (burst_start_i) begin
      nxt_r.st = cyhc_pkg::ST_ARMED;
      nxt_r.wr = '0;
      nxt_r.rd = '0;
      nxt_r.total = '0;
      nxt_r.sent = '0;
      nxt_r.vcnt = '0;
      nxt_r.ccnt = '0;
      nxt_r.fetch = 1'b0;
      wr_en = 1'b0;
      push = 1'b0;
    end
    // Register writes, a fetch set wins over its clear
    if (acc) begin
      nxt_r.pready = 1'b1;
      nxt_r.prdata = '0;
      if (paddr_i == cyhc_pkg::ADDR_CTRL) begin
        if (pwrite_i) begin
          nxt_r.fin = pwdata_i[cyhc_pkg::CTRL_FIN_BIT];
          nxt_r.all = pwdata_i[cyhc_pkg::CTRL_ALL_BIT];
          nxt_r.tt = pwdata_i[cyhc_pkg::CTRL_TT_LSB +: 2];
          if (pwdata_i[cyhc_pkg::CTRL_FETCH_BIT]) begin
            nxt_r.fetch = 1'b1;
          end
        end
        nxt_r.prdata = {27'h000_0000, r_ff.fetch, r_ff.tt, r_ff.all,
                        r_ff.fin};
      end else if (paddr_i == cyhc_pkg::ADDR_PRE) begin
        if (pwrite_i) nxt_r.pre = pwdata_i;
        nxt_r.prdata = r_ff.pre;
      end else if (paddr_i == cyhc_pkg::ADDR_MAXS) begin
        if (pwrite_i) nxt_r.maxs = pwdata_i;
        nxt_r.prdata = r_ff.maxs;
      end else if (paddr_i == cyhc_pkg::ADDR_TCYC) begin
        if (pwrite_i) nxt_r.tcyc = pwdata_i;
        nxt_r.prdata = r_ff.tcyc;
      end else if (paddr_i == cyhc_pkg::ADDR_VOFF) begin
        if (pwrite_i) nxt_r.voff = pwdata_i;
        nxt_r.prdata = r_ff.voff;
      end else if (paddr_i == cyhc_pkg::ADDR_COFF) begin
        if (pwrite_i) nxt_r.coff = pwdata_i;
        nxt_r.prdata = r_ff.coff;
      end else if (paddr_i == cyhc_pkg::ADDR_HBUF) begin
        if (pwrite_i) nxt_r.hbuf = pwdata_i;
        nxt_r.prdata = r_ff.hbuf;
      end else if (paddr_i == cyhc_pkg::ADDR_STAT) begin
        nxt_r.prdata = {11'h000, 16'(occ), r_ff.st};
      end else if (paddr_i == cyhc_pkg::ADDR_CNT) begin
        nxt_r.prdata = r_ff.total;
      end else begin
        nxt_r.pslverr = 1'b1; // Unmapped address
      end
    end
  end
  // State register and history memory
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      r_ff <= '0;
      r_ff.st <= cyhc_pkg::ST_IDLE;
      r_ff.fin <= cyhc_pkg::RST_CTRL[cyhc_pkg::CTRL_FIN_BIT];
      r_ff.maxs <= cyhc_pkg::RST_MAXS;
      r_ff.hbuf <= cyhc_pkg::RST_HBUF;
    end else begin
      r_ff <= nxt_r;
    end
    if (wr_en) begin
      hist_ff[r_ff.wr[AW-1:0]] <= {cyc_num_i, cyc_fail_i};
    end
  end
  // Sample FIFO towards the host buffer
  cyhc_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) cyhc_fifo_i (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_rdy),
    .in_data_i(hist_ff[r_ff.rd[AW-1:0]]),
    .out_valid_o(smp_valid_o),
    .out_ready_i(smp_ready_i),
    .out_data_o(smp_data_o)
  );
  assign prdata_o = r_ff.prdata;
  assign pready_o = r_ff.pready;
  assign pslverr_o = r_ff.pslverr;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  fail_only_a: assert property (
    wr_en && r_ff.st == cyhc_pkg::ST_CAPT && !r_ff.all |-> fail)
    else $error("non-failing cycle recorded in failures-only mode");
  all_cycles_a: assert property (
    r_ff.st == cyhc_pkg::ST_CAPT && r_ff.all && cyc_valid_i && room &&
    !burst_start_i |=> r_ff.wr == $past(r_ff.wr) + 1'b1)
    else $error("cycle not recorded in every-cycle mode");
  limit_a: assert property (
    wr_en && r_ff.maxs != cyhc_pkg::MAXS_UNLIMITED |->
    r_ff.total < r_ff.maxs && (!r_ff.fin || r_ff.total < DEPTH_W))
    else $error("sample written beyond the limit");
  reset_dflt_a: assert property (disable iff (1'b0)
    sys_rst_i |=> r_ff.fin && r_ff.hbuf == cyhc_pkg::RST_HBUF)
    else $error("wrong defaults after reset");
  fetch_hold_a: assert property (
    r_ff.fin && !r_ff.fetch |-> !push)
    else $error("finite sample sent without fetch");
  auto_stream_a: assert property (
    !r_ff.fin && r_ff.st == cyhc_pkg::ST_CAPT && occ != '0 && fifo_rdy &&
    r_ff.sent < r_ff.hbuf && !burst_start_i |-> ##1 $past(push))
    else $error("continuous mode did not stream");
  miscmp_trig_a: assert property (
    r_ff.st == cyhc_pkg::ST_ARMED && r_ff.tt == cyhc_pkg::TT_MISCOMPARE &&
    cyc_valid_i && fail && !burst_start_i |=> r_ff.st == cyhc_pkg::ST_CAPT)
    else $error("miscompare trigger missed");
  cycle_trig_a: assert property (
    r_ff.st == cyhc_pkg::ST_ARMED && r_ff.tt == cyhc_pkg::TT_CYCLE &&
    cyc_valid_i && cyc_num_i == r_ff.tcyc && !burst_start_i
    |=> r_ff.st == cyhc_pkg::ST_CAPT)
    else $error("cycle trigger missed");
  burst_clear_a: assert property (
    burst_start_i |=> r_ff.st == cyhc_pkg::ST_ARMED && r_ff.total == '0 &&
    occ == '0 ##1 !(r_ff.st == cyhc_pkg::ST_IDLE))
    else $error("burst start did not rearm");
  pre_window_a: assert property (
    r_ff.st inside {cyhc_pkg::ST_ARMED, cyhc_pkg::ST_VSKIP,
    cyhc_pkg::ST_CSKIP} && !$past(burst_start_i) |-> 32'(occ) <= pre_cap)
    else $error("pretrigger window too large");
endmodule

// ### verification/cyhc_engine.sv
// Purpose: Burst engine and host fetch model for the capture block
// Assumes: Driven at rising edges; one cycle per clock during a burst
// Notes: Host side can stall by toggling ready every clock
module cyhc_engine #(
  parameter int PINS = 8
) (
  input wire logic clock_i,
  output logic burst_start_o,
  output logic cyc_valid_o,
  output logic [31:0] cyc_num_o,
  output logic [PINS-1:0] cyc_fail_o,
  output logic label_hit_o,
  output logic vector_start_o,
  output logic smp_ready_o,
  input wire logic smp_valid_i,
  input wire logic [31+PINS:0] smp_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall;
  logic [31+PINS:0] got[$];

  // Idle levels at time zero
  initial begin
    burst_start_o = 1'b0;
    cyc_valid_o = 1'b0;
    cyc_num_o = '0;
    cyc_fail_o = '0;
    label_hit_o = 1'b0;
    vector_start_o = 1'b0;
    smp_ready_o = 1'b1;
    stall = 1'b0;
  end

  // Failing pins of cycle i when its mask bit is set
  function automatic logic [PINS-1:0] fval(input int i,
                                           input logic [31:0] mask);
    return mask[i] ? PINS'(8'hA5 ^ i[7:0]) : '0;
  endfunction

  // One burst of n cycles; label at cycle lab, a vector every 2 cycles
  task automatic burst(input int n, input logic [31:0] mask,
                       input int lab);
    int i;
    @(posedge clock_i);
    burst_start_o <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clock_i);
      burst_start_o <= 1'b0;
      cyc_valid_o <= 1'b1;
      cyc_num_o <= 32'(i);
      cyc_fail_o <= fval(i, mask);
      label_hit_o <= (i == lab);
      vector_start_o <= (i >= lab) && ((i - lab) % 2 == 0);
    end
    @(posedge clock_i);
    cyc_valid_o <= 1'b0;
    cyc_num_o <= ~cyc_num_o;
    cyc_fail_o <= ~cyc_fail_o;
    label_hit_o <= 1'b0;
    vector_start_o <= 1'b0;
  endtask

  // Host collects samples, stalling every other clock when asked
  always @(posedge clock_i) begin
    if (smp_valid_i === 1'b1 && smp_ready_o) begin
      got.push_back(smp_data_i);
    end
    smp_ready_o <= stall ? ~smp_ready_o : 1'b1;
  end
endmodule

// ### verification/cyhc_capture_tb.sv
// Purpose: Self-checking bench for the cycle history capture block
// Assumes: APB slave answers with one wait state; 8 pins
// Notes: Each scenario is its own task and judges its own results
module cyhc_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, bst, cval, lhit, vst, sval, srdy;
  logic [31:0] cnum;
  logic [7:0] cfail;
  logic [39:0] sdata;
  int fail_count = 0;
  int check_count = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  cyhc_capture cyhc_capture_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .burst_start_i(bst),
    .cyc_valid_i(cval), .cyc_num_i(cnum), .cyc_fail_i(cfail),
    .label_hit_i(lhit), .vector_start_i(vst), .smp_valid_o(sval),
    .smp_ready_i(srdy), .smp_data_o(sdata));
  cyhc_engine cyhc_engine_i (.clock_i(clock_i), .burst_start_o(bst),
    .cyc_valid_o(cval), .cyc_num_o(cnum), .cyc_fail_o(cfail),
    .label_hit_o(lhit), .vector_start_o(vst), .smp_ready_o(srdy),
    .smp_valid_i(sval), .smp_data_i(sdata));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) fail_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, 40'(x), 40'(r));
  endtask

  // Waits for the expected samples, then compares number and content
  task automatic cmp(input int ex[8], input int nex,
                     input logic [31:0] mask);
    int n;
    int i;
    n = 0;
    while (cyhc_engine_i.got.size() < nex && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    repeat (20) @(posedge clock_i);
    chk("sample count", 40'(nex), 40'(cyhc_engine_i.got.size()));
    for (i = 0; i < nex && i < cyhc_engine_i.got.size(); i++) begin
      chk("sample", {32'(ex[i]), cyhc_engine_i.fval(ex[i], mask)},
          cyhc_engine_i.got[i]);
    end
    cyhc_engine_i.got.delete();
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rchk("control", cyhc_pkg::ADDR_CTRL, cyhc_pkg::RST_CTRL);
    rchk("max samples", cyhc_pkg::ADDR_MAXS, 32'hFFFF_FFFF);
    rchk("host buffer", cyhc_pkg::ADDR_HBUF, 32'h0000_7D00);
    apb(1'b0, 8'h40, 32'h0000_0000, r, e);
    chk("unmapped error", 40'h00_0000_0001, 40'(e));
    $display("test reset done");
  endtask

  // Continuous, every cycle, cycle trigger at 5 with 2 pretrigger
  task automatic t_cycle();
    cyhc_engine_i.stall = 1'b1;
    w(cyhc_pkg::ADDR_CTRL, 32'h0000_0006);
    w(cyhc_pkg::ADDR_PRE, 32'h0000_0002);
    w(cyhc_pkg::ADDR_TCYC, 32'h0000_0005);
    cyhc_engine_i.burst(10, 32'h0000_0080, -1);
    cmp('{3, 4, 5, 6, 7, 8, 9, 0}, 7,
        32'h0000_0080);
    $display("test cycle trigger done");
  endtask

  // Finite, failures only, earliest miscompare trigger
  task automatic t_fail();
    w(cyhc_pkg::ADDR_CTRL, 32'h0000_0001);
    w(cyhc_pkg::ADDR_PRE, 32'h0000_0000);
    cyhc_engine_i.burst(12, 32'h0000_0250, -1);
    repeat (20) @(posedge clock_i);
    chk("before fetch", 40'h0, 40'(cyhc_engine_i.got.size()));
    w(cyhc_pkg::ADDR_CTRL, 32'h0000_0011);
    cmp('{4, 6, 9, 0, 0, 0, 0, 0}, 3, 32'h0000_0250);
    $display("test miscompare trigger done");
  endtask

  // Label at 2, skip one vector then one cycle, limit of 3 samples
  task automatic t_label();
    w(cyhc_pkg::ADDR_CTRL, 32'h0000_000A);
    w(cyhc_pkg::ADDR_MAXS, 32'h0000_0003);
    w(cyhc_pkg::ADDR_VOFF, 32'h0000_0001);
    w(cyhc_pkg::ADDR_COFF, 32'h0000_0001);
    cyhc_engine_i.burst(12, 32'h0000_0040, 2);
    cmp('{5, 6, 7, 0, 0, 0, 0, 0}, 3,
        32'h0000_0040);
    rchk("captured count", cyhc_pkg::ADDR_CNT, 32'h0000_0003);
    rchk("status", cyhc_pkg::ADDR_STAT, 32'h0000_0010);
    $display("test label trigger done");
  endtask

  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_cycle();
    t_fail();
    t_label();
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    complete_run();
  end
endmodule
